// ### sgig_top.sv
// Global interrupt gating: global and per-port status, masks and request
//
// Summary of operation
// RL1: Global mask bit 31 enables the lookup engine interrupt when 0 and blocks it when 1.
// RL2: Global mask bit 30 enables the trigger/timestamp unit interrupt when 0 and blocks it when 1.
// RL3: Global mask bits 29..0 enable the bus timeout interrupts when 0 and block them when 1.
// RL4: All global mask bits are read/write and reset to 0, so every global source starts enabled.
// RL5: Port summary status bits 6..0 show ports 7..1 requesting, read-only, reset to 0.
// RL6: Port summary bits only mirror each port's aggregate request; causes live in port registers.
// RL7: Port mask bits 6..0 are read/write, reset to 0 (enabled), and 1 disables that port.
// RL8: A port summary bit reaches the device interrupt only while its port mask bit is clear.
// RL9: Bits 31..7 of the port status and port mask registers are reserved and read-only.
// RL10: Global status shows lookup at 31, trigger at 30, timeouts at 29..0, read-only, reset 0.
// RL11: The interrupt request is high while any unmasked status bit is set, low otherwise.
// RL12: Software writes 0 to reserved port bits and preserves read-back values on updates.
`timescale 1ns/100ps
`default_nettype none
module sgig_top
   import sgig_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [sgig_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [sgig_pkg::DATA_W-1:0] reg_wdata,
   output logic [sgig_pkg::DATA_W-1:0] reg_rdata_r,
   input wire logic lookup_engine_req,
   input wire logic trig_ts_req,
   input wire logic [sgig_pkg::TMO_W-1:0] bus_timeout_req,
   input wire logic [sgig_pkg::PORT_N-1:0] port_req,
   output logic irq_r
);
   import sgig_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Status capture

   logic [31:0] glb_stat_r, glb_stat_nxt;
   logic [6:0] port_stat_r, port_stat_nxt;

   always_comb begin
      glb_stat_nxt = {lookup_engine_req, trig_ts_req, bus_timeout_req}; // RL10
      // Level mirror of each port's aggregate request only
      port_stat_nxt = port_req; // RL5 RL6
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         glb_stat_r <= GLB_STAT_RST;
         port_stat_r <= PORT_STAT_RST;
      end else begin
         glb_stat_r <= glb_stat_nxt;
         port_stat_r <= port_stat_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mask registers

   logic [31:0] glb_mask_r, glb_mask_nxt;
   logic [6:0] port_mask_r, port_mask_nxt;

   always_comb begin
      glb_mask_nxt = glb_mask_r;
      port_mask_nxt = port_mask_r;
      if (reg_wr && reg_addr == OFS_GLB_MASK) begin
         glb_mask_nxt = reg_wdata; // RL1 RL2 RL3 RL4
      end
      if (reg_wr && reg_addr == OFS_PORT_MASK) begin
         // Upper bits are dropped; reserved field has no storage
         port_mask_nxt = reg_wdata[6:0]; // RL7 RL9
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         glb_mask_r <= GLB_MASK_RST;
         port_mask_r <= PORT_MASK_RST;
      end else begin
         glb_mask_r <= glb_mask_nxt;
         port_mask_r <= port_mask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port, one cycle latency

   logic [31:0] rdata_nxt;

   always_comb begin
      rdata_nxt = reg_rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            OFS_GLB_STATUS: rdata_nxt = glb_stat_r;
            OFS_GLB_MASK: rdata_nxt = glb_mask_r;
            OFS_PORT_STATUS: rdata_nxt = {25'h0, port_stat_r}; // RL9
            OFS_PORT_MASK: rdata_nxt = {25'h0, port_mask_r}; // RL9
            default: rdata_nxt = RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata_r <= RD_UNMAPPED;
      end else begin
         reg_rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gating and request

   logic glb_req_r, port_req_r, irq_nxt;

   sgig_gate #(.W(32)) u_glb_gate (
      .clk(clk),
      .rst(rst),
      .stat(glb_stat_r),
      .mask(glb_mask_r),
      .req_r(glb_req_r)
   ); // RL1 RL2 RL3

   sgig_gate #(.W(7)) u_port_gate (
      .clk(clk),
      .rst(rst),
      .stat(port_stat_r),
      .mask(port_mask_r),
      .req_r(port_req_r)
   ); // RL8

   always_comb begin
      irq_nxt = glb_req_r | port_req_r; // RL11
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // Request path: status/mask registers, gate flop, irq flop
   sequence s_unmasked_hit;
      (|(glb_stat_r & ~glb_mask_r)) || (|(port_stat_r & ~port_mask_r));
   endsequence

   AST_IRQ_SET: assert property (@(posedge clk) disable iff (rst) // RL11
      s_unmasked_hit |-> ##2 irq_r)
      else $error("irq not raised two cycles after unmasked status");

   AST_IRQ_CLR: assert property (@(posedge clk) disable iff (rst) // RL11
      !(|(glb_stat_r & ~glb_mask_r)) && !(|(port_stat_r & ~port_mask_r)) |-> ##2 !irq_r)
      else $error("irq high with no unmasked status");

   AST_LOOKUP_MASK: assert property (@(posedge clk) disable iff (rst) // RL1
      glb_stat_r[BIT_LOOKUP] && !glb_mask_r[BIT_LOOKUP] |-> ##1 glb_req_r)
      else $error("unmasked lookup engine request not gated through");

   AST_TRIG_MASK: assert property (@(posedge clk) disable iff (rst) // RL2
      glb_stat_r == 32'h4000_0000 && glb_mask_r[BIT_TRIG] |-> ##1 !glb_req_r)
      else $error("masked trigger request leaked");

   AST_TMO_MASK: assert property (@(posedge clk) disable iff (rst) // RL3
      glb_stat_r[29:0] != 30'h0 && glb_stat_r[31:30] == 2'h0
      && (glb_stat_r[29:0] & ~glb_mask_r[29:0]) == 30'h0 |-> ##1 !glb_req_r)
      else $error("masked timeout request leaked");

   AST_GMASK_WR: assert property (@(posedge clk) disable iff (rst) // RL4
      reg_wr && reg_addr == OFS_GLB_MASK |=> glb_mask_r == $past(reg_wdata))
      else $error("global mask write not stored");

   AST_PSTAT_FOLLOW: assert property (@(posedge clk) disable iff (rst) // RL5
      1'b1 |=> port_stat_r == $past(port_req))
      else $error("port status does not follow port requests");

   AST_PMASK_RD: assert property (@(posedge clk) disable iff (rst) // RL7
      reg_rd && reg_addr == OFS_PORT_MASK |=> reg_rdata_r == {25'h0, $past(port_mask_r)})
      else $error("port mask read-back wrong");

   AST_PORT_GATE: assert property (@(posedge clk) disable iff (rst) // RL8
      (port_stat_r & ~port_mask_r) == 7'h00 |=> !port_req_r)
      else $error("masked port request leaked");

   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst) // RL9
      reg_rd && reg_addr == OFS_PORT_STATUS |=> reg_rdata_r[31:7] == 25'h0)
      else $error("reserved port status bits not zero");

   AST_GSTAT_RD: assert property (@(posedge clk) disable iff (rst) // RL10
      reg_rd && reg_addr == OFS_GLB_STATUS |=> reg_rdata_r == $past(glb_stat_r))
      else $error("global status read-back wrong");

   // Other direction per global source: trigger and timeouts must pass when enabled, lookup be blocked when masked
   AST_LOOKUP_BLOCK: assert property (@(posedge clk) disable iff (rst) // RL1
      glb_stat_r == 32'h8000_0000 && glb_mask_r[BIT_LOOKUP] |-> ##1 !glb_req_r)
      else $error("masked lookup engine request leaked");

   AST_TRIG_PASS: assert property (@(posedge clk) disable iff (rst) // RL2
      glb_stat_r[BIT_TRIG] && !glb_mask_r[BIT_TRIG] |-> ##1 glb_req_r)
      else $error("unmasked trigger request not gated through");

   AST_TMO_PASS: assert property (@(posedge clk) disable iff (rst) // RL3
      (glb_stat_r[29:0] & ~glb_mask_r[29:0]) != 30'h0 |-> ##1 glb_req_r)
      else $error("unmasked timeout request not gated through");

   AST_GMASK_HOLD: assert property (@(posedge clk) disable iff (rst) // RL4
      !(reg_wr && reg_addr == OFS_GLB_MASK) |=> $stable(glb_mask_r))
      else $error("global mask changed without a write");

   AST_PMASK_WR: assert property (@(posedge clk) disable iff (rst) // RL7
      reg_wr && reg_addr == OFS_PORT_MASK
      |=> {25'h0, port_mask_r} == ($past(reg_wdata) & 32'h0000_007f))
      else $error("port mask write not stored");

   AST_PORT_PASS: assert property (@(posedge clk) disable iff (rst) // RL8
      (port_stat_r & ~port_mask_r) != 7'h00 |=> port_req_r)
      else $error("unmasked port request not gated through");

   AST_GSTAT_FOLLOW: assert property (@(posedge clk) disable iff (rst) // RL10
      1'b1 |=> glb_stat_r[BIT_LOOKUP] == $past(lookup_engine_req)
      && glb_stat_r[BIT_TRIG] == $past(trig_ts_req)
      && glb_stat_r[29:0] == $past(bus_timeout_req))
      else $error("global status does not follow source requests");
endmodule
`default_nettype wire

// ### sgig_pkg.sv
// Package for the switch global interrupt gating block
package sgig_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PORT_N = 7;
   localparam logic [15:0] OFS_GLB_STATUS = 16'h0010;
   localparam logic [15:0] OFS_GLB_MASK = 16'h0014;
   localparam logic [15:0] OFS_PORT_STATUS = 16'h0018;
   localparam logic [15:0] OFS_PORT_MASK = 16'h001c;
   localparam int unsigned BIT_LOOKUP = 31;
   localparam int unsigned BIT_TRIG = 30;
   localparam int unsigned TMO_W = 30;
   localparam logic [31:0] GLB_MASK_RST = 32'h0000_0000;
   localparam logic [6:0] PORT_MASK_RST = 7'h00;
   localparam logic [6:0] PORT_STAT_RST = 7'h00;
   localparam logic [31:0] GLB_STAT_RST = 32'h0000_0000;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ### sgig_gate.sv
// Per-bit status/mask gate with registered any-request result
`timescale 1ns/100ps
`default_nettype none
module sgig_gate #(
   parameter int unsigned W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] stat,
   input wire logic [W-1:0] mask,
   output logic req_r
);
   logic req_nxt;

   always_comb begin
      // Mask bit clear means enabled
      req_nxt = |(stat & ~mask);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_r <= 1'b0;
      end else begin
         req_r <= req_nxt;
      end
   end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the global interrupt gating block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import sgig_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic lk = 1'b0;
   logic tr = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [31:0] reg_rdata_r;
   logic [29:0] tmo = 30'h0000_0000;
   logic [6:0] preq = 7'h00;
   logic irq_r;
   int n_errors = 0;
   int n_compared = 0;

   sgig_top u_sgig_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
      .lookup_engine_req(lk), .trig_ts_req(tr), .bus_timeout_req(tmo),
      .port_req(preq), .irq_r(irq_r));

   always #2.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task cmp32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: register read %h, expected %h", $time, got, exp);
      end
   endtask

   task cmp1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: irq %b, expected %b", $time, got, exp);
      end
   endtask

   // Bus tasks start and end at a falling edge; the idle cycle at the end
   // keeps a following call from re-driving a strobe in the same time step
   task wr(input logic [15:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask

   task rdc(input logic [15:0] a, input logic [31:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      cmp32(reg_rdata_r, exp);
      @(negedge clk);
   endtask

   // Three flops between cause and irq; four cycles leave margin
   task irqc(input logic exp);
      repeat (4) @(negedge clk);
      cmp1(irq_r, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      rdc(OFS_GLB_MASK, 32'h0000_0000);
      rdc(OFS_PORT_MASK, 32'h0000_0000);
      rdc(OFS_PORT_STATUS, 32'h0000_0000);
      rdc(OFS_GLB_STATUS, 32'h0000_0000);
      cmp1(irq_r, 1'b0);
   endtask

   task t_global;
      logic [31:0] v;
      for (int i = 0; i < 4; i++) begin
         v = 32'h0000_0001 << ((i == 0) ? 31 : (i == 1) ? 30 : (i == 2) ? 0 : 29);
         {lk, tr, tmo} = v;
         irqc(1'b1);
         rdc(OFS_GLB_STATUS, v);
         wr(OFS_GLB_MASK, v);
         irqc(1'b0);
         wr(OFS_GLB_MASK, ~v);
         irqc(1'b1);
         rdc(OFS_GLB_MASK, ~v);
         wr(OFS_GLB_MASK, 32'h0000_0000);
         {lk, tr, tmo} = 32'h0000_0000;
         irqc(1'b0);
      end
   endtask

   task t_port;
      logic [6:0] v;
      for (int i = 0; i < 7; i++) begin
         v = 7'h01 << i;
         preq = v;
         irqc(1'b1);
         rdc(OFS_PORT_STATUS, {25'h0, v});
         wr(OFS_PORT_MASK, {25'h0, v});
         irqc(1'b0);
         // Reserved bits are always written as zero
         wr(OFS_PORT_MASK, {25'h0, ~v});
         irqc(1'b1);
         rdc(OFS_PORT_MASK, {25'h0, ~v});
         wr(OFS_PORT_STATUS, {25'h0, 7'h7f});
         rdc(OFS_PORT_STATUS, {25'h0, v});
         wr(OFS_PORT_MASK, 32'h0000_0000);
         preq = 7'h00;
         irqc(1'b0);
      end
      rdc(16'h0020, 32'h0000_0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task test_done;
      $display("Mismatches %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_reset;
      t_global;
      t_port;
      test_done;
   end

   // About 330 cycles expected; 4000 cycles means a hang
   initial begin
      #20000;
      n_errors++;
      test_done;
   end
endmodule
`default_nettype wire
